// ---- design/pmh_core.sv ----
// Purpose: link power state and turn-off handshake control
// Assumes: all inputs synchronous to clk; l1AckRx and turnoffMsgRx arrive as pulses, linkTrained, linkIdle and asyncClkMode as levels
// Notes:   function 0 is the requester function
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module pmh_core
  import pmh_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // link events
  input  wire logic                  linkTrained,
  input  wire logic                  linkIdle,
  input  wire logic                  l1AckRx,
  input  wire logic                  turnoffMsgRx,
  input  wire logic                  asyncClkMode,
  // configuration writes of the power state
  input  wire logic                  dstateWrValid,
  input  wire logic                  dstateWrFunc,
  input  wire logic [1:0]            dstateWrValue,
  // link side outputs
  output logic [7:0]                 ftsAdvertised,
  output logic [2:0]                 linkState,
  output logic                       enterL1DllpTx,
  output logic                       pmeToAckTx,
  output logic                       layersDisabled,
  // user requester and completer streams
  input  wire logic                  requesterValid,
  input  wire logic                  requesterLast,
  output logic                       requester_accept_out,
  output logic                       completerAccept,
  // user power handshake
  output logic [2*NUM_FUNC-1:0]      functionPowerState,
  output logic                       turnoff_notice_out,
  input  wire logic                  powerChangeAck,
  // AXI4-Lite
  input  wire logic [3:0]            awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [3:0]            araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);
  pmh_link_t    link_ff;
  pmh_link_t    nxt_link;
  pmh_turnoff_t to_ff;
  pmh_turnoff_t nxt_to;
  pmh_dstate_t  dst_ff [NUM_FUNC];
  logic [7:0]   idleCnt_ff;
  logic         inPacket_ff;
  logic         notice_ff;
  logic         enterL1_ff;
  logic         pmeAck_ff;
  logic [2:0]   ctrlBits;
  logic         aspmOn;
  logic         allD0;
  logic         reqFire;
  logic         dstWrOk;
  logic         closed;

  // D1 and D2 writes only count when the state is supported
  function automatic logic dstate_ok(input logic [1:0] v);
    return (v == DST_D0) || (v == DST_D3HOT) || (v == DST_D1 && D1_SUPPORTED) || (v == DST_D2 && D2_SUPPORTED);
  endfunction

  assign dstWrOk = dstateWrValid && dstate_ok(dstateWrValue);
  assign closed  = (to_ff == TO_OFF);
  assign allD0   = (dst_ff[0] == DST_D0) && (dst_ff[1] == DST_D0);
  // async clocking breaks the fast training realignment
  assign aspmOn  = ctrlBits[CTRL_ASPM_BIT] && !asyncClkMode;
  assign ftsAdvertised = FTS_COUNT;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dst_ff[0] <= DST_D0;
      dst_ff[1] <= DST_D0;
    end
    else if (dstWrOk && !closed)
      dst_ff[dstateWrFunc] <= pmh_dstate_t'(dstateWrValue);
  end

  generate
    for (genvar f = 0; f < NUM_FUNC; f++)
    begin : g_fps
      assign functionPowerState[2*f+1:2*f] = dst_ff[f];
    end
  endgenerate

  // link state
  always_comb
  begin
    nxt_link = link_ff;
    unique case (link_ff)
      LNK_DOWN:
        if (linkTrained)
          nxt_link = LNK_L0;
      LNK_L0:
        if (turnoffMsgRx)
          nxt_link = LNK_L23;
        else if (!allD0)
          nxt_link = LNK_L1ENT;
        else if (aspmOn && linkIdle && idleCnt_ff == L0S_IDLE_CNT)
          nxt_link = LNK_L0S;
      LNK_L0S:
        if (turnoffMsgRx)
          nxt_link = LNK_L23;
        else if (!linkIdle || !aspmOn || !allD0)
          nxt_link = LNK_L0;
      LNK_L1ENT:
        if (allD0)
          nxt_link = LNK_L0;
        else if (l1AckRx)
          nxt_link = LNK_L1;
      LNK_L1:
        if (turnoffMsgRx)
          nxt_link = LNK_L23;
        else if (allD0)
          nxt_link = LNK_L0;
      LNK_L23:
        nxt_link = LNK_L23;
      default:
        nxt_link = LNK_DOWN;
    endcase
    if (!linkTrained && link_ff != LNK_L23)
      nxt_link = LNK_DOWN;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      link_ff <= LNK_DOWN;
    else
      link_ff <= nxt_link;
  end

  // idle timer for autonomous standby
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      idleCnt_ff <= 8'h0;
    else if (link_ff != LNK_L0 || !linkIdle)
      idleCnt_ff <= 8'h0;
    else if (idleCnt_ff != L0S_IDLE_CNT)
      idleCnt_ff <= idleCnt_ff + 8'h1;
  end

  // one entry request packet per entry attempt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enterL1_ff <= 1'b0;
    else
      enterL1_ff <= (nxt_link == LNK_L1ENT) && (link_ff != LNK_L1ENT);
  end

  // turn-off handshake
  always_comb
  begin
    nxt_to = to_ff;
    unique case (to_ff)
      TO_IDLE:
        if (turnoffMsgRx && link_ff != LNK_DOWN)
          nxt_to = TO_NOTIFY;
      TO_NOTIFY:
        if (powerChangeAck)
          nxt_to = TO_ACK;
      TO_ACK:
        nxt_to = TO_OFF;
      TO_OFF:
        nxt_to = TO_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      to_ff <= TO_IDLE;
    else
      to_ff <= nxt_to;
  end

  // registered so the notice falls one edge after the acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      notice_ff <= 1'b0;
    else
      notice_ff <= (nxt_to == TO_NOTIFY);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pmeAck_ff <= 1'b0;
    else
      pmeAck_ff <= (to_ff == TO_NOTIFY) && powerChangeAck;
  end

  // packet tracking so a started request finishes
  assign reqFire = requesterValid && requester_accept_out;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      inPacket_ff <= 1'b0;
    else if (reqFire)
      inPacket_ff <= !requesterLast;
  end

  // root port and user config space completions keep flowing outside D0
  assign requester_accept_out = !closed && (inPacket_ff || dst_ff[0] == DST_D0);
  assign completerAccept      = !closed &&
                                (allD0 || ctrlBits[CTRL_UCFG_BIT] || ctrlBits[CTRL_ROOT_BIT]);

  assign linkState          = link_ff;
  assign enterL1DllpTx      = enterL1_ff;
  assign pmeToAckTx         = pmeAck_ff;
  assign layersDisabled     = closed;
  assign turnoff_notice_out = notice_ff;

  pmh_regs u_regs (
    .clk        (clk),
    .rst_n      (rst_n),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wready),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arready),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .statusWord ({20'h0, functionPowerState, 2'h0, aspmOn, closed, notice_ff, link_ff}),
    .ctrlBits   (ctrlBits)
  );

  a_fts_const: assert property (@(posedge clk) disable iff (!rst_n) ftsAdvertised == 8'hFF)
    else $error("fts count not 255");
  a_no_async_l0s: assert property (@(posedge clk) disable iff (!rst_n)
    asyncClkMode |=> link_ff != LNK_L0S)
    else $error("standby entered in async clocking");
  a_l0_after_train: assert property (@(posedge clk) disable iff (!rst_n)
    $past(link_ff) == LNK_DOWN && link_ff == LNK_L0 |-> $past(linkTrained))
    else $error("L0 without training");
  a_l1_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(link_ff == LNK_L1ENT) |-> $past(!allD0))
    else $error("L1 entry without low power state");
  a_l1_dllp: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(link_ff == LNK_L1ENT) |-> enterL1DllpTx)
    else $error("no entry packet on L1 entry");
  a_req_stall: assert property (@(posedge clk) disable iff (!rst_n)
    dst_ff[0] != DST_D0 && !inPacket_ff |-> !requester_accept_out)
    else $error("requester accepted outside D0");
  a_l23_entry: assert property (@(posedge clk) disable iff (!rst_n)
    turnoffMsgRx && linkTrained && link_ff inside {LNK_L0, LNK_L0S, LNK_L1} |=> link_ff == LNK_L23)
    else $error("turn-off did not reach L23");
  a_notice_rise: assert property (@(posedge clk) disable iff (!rst_n)
    to_ff == TO_IDLE && turnoffMsgRx && link_ff != LNK_DOWN |=> turnoff_notice_out)
    else $error("notice not raised");
  a_notice_hold: assert property (@(posedge clk) disable iff (!rst_n)
    turnoff_notice_out && !powerChangeAck |=> turnoff_notice_out)
    else $error("notice dropped before acknowledge");
  a_notice_fall: assert property (@(posedge clk) disable iff (!rst_n)
    turnoff_notice_out && powerChangeAck |=> !turnoff_notice_out ##1 !turnoff_notice_out)
    else $error("notice did not fall after acknowledge");
  a_pme_ack: assert property (@(posedge clk) disable iff (!rst_n)
    turnoff_notice_out && powerChangeAck |=> pmeToAckTx ##1 (!pmeToAckTx && layersDisabled))
    else $error("turn-off acknowledge missing");
  a_closed_off: assert property (@(posedge clk) disable iff (!rst_n)
    layersDisabled |-> !requester_accept_out && !completerAccept)
    else $error("interfaces open after turn-off");
  a_l0s_exit: assert property (@(posedge clk) disable iff (!rst_n)
    link_ff == LNK_L0S && !linkIdle && linkTrained && !turnoffMsgRx |=> link_ff == LNK_L0)
    else $error("standby not left on traffic");
  a_fps_out: assert property (@(posedge clk) disable iff (!rst_n)
    dstWrOk && !closed |=> ($past(dstateWrFunc) ? functionPowerState[3:2] : functionPowerState[1:0]) == $past(dstateWrValue))
    else $error("power state not reported");
endmodule

// ---- common/pmh_pkg.sv ----
// Purpose: shared constants for the power management handshake block
// Assumes: 25 MHz user clock, two functions, AXI4-Lite register access
// Notes:   device power states use the standard two-bit encoding
package pmh_pkg;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          NUM_FUNC        = 2;
  localparam logic [7:0]  FTS_COUNT       = 8'hFF;
  // idle time on the link before an autonomous L0s entry
  localparam int          L0S_IDLE_NS     = 7000;
  localparam int          L0S_IDLE_CYC    = L0S_IDLE_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  L0S_IDLE_CNT    = 8'(L0S_IDLE_CYC);
  localparam logic        D1_SUPPORTED    = 1'b1;
  localparam logic        D2_SUPPORTED    = 1'b1;

  typedef enum logic [1:0] {
    DST_D0    = 2'b00,
    DST_D1    = 2'b01,
    DST_D2    = 2'b10,
    DST_D3HOT = 2'b11
  } pmh_dstate_t;

  typedef enum logic [2:0] {
    LNK_DOWN  = 3'b000,
    LNK_L0    = 3'b001,
    LNK_L0S   = 3'b010,
    LNK_L1ENT = 3'b011,
    LNK_L1    = 3'b100,
    LNK_L23   = 3'b101
  } pmh_link_t;

  typedef enum logic [1:0] {
    TO_IDLE   = 2'b00,
    TO_NOTIFY = 2'b01,
    TO_ACK    = 2'b10,
    TO_OFF    = 2'b11
  } pmh_turnoff_t;

  // register map, byte addresses
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_FTS        = 4'h8;
  localparam logic [2:0]  CTRL_RESET      = 3'h1;
  localparam int          CTRL_ASPM_BIT   = 0;
  localparam int          CTRL_UCFG_BIT   = 1;
  localparam int          CTRL_ROOT_BIT   = 2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ---- design/pmh_regs.sv ----
// Purpose: AXI4-Lite register slave for the power management block
// Assumes: one write and one read outstanding at most
// Notes:   write address and data may arrive in either order
`timescale 1ns/1ns
module pmh_regs
  import pmh_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write channels
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // block side
  input  wire logic [31:0] statusWord,
  output logic [2:0]       ctrlBits
);
  logic        awHeld_ff;
  logic        wHeld_ff;
  logic [3:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic        wLane_ff;
  logic [2:0]  ctrl_ff;
  logic [1:0]  bresp_ff;
  logic        bvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        rvalid_ff;
  logic        doWrite;

  assign awready  = !awHeld_ff && !bvalid_ff;
  assign wready   = !wHeld_ff && !bvalid_ff;
  assign arready  = !rvalid_ff;
  assign doWrite  = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign bresp    = bresp_ff;
  assign bvalid   = bvalid_ff;
  assign rdata    = rdata_ff;
  assign rresp    = rresp_ff;
  assign rvalid   = rvalid_ff;
  assign ctrlBits = ctrl_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff  <= 32'h0;
      wLane_ff  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      else if (doWrite)
        awHeld_ff <= 1'b0;
      if (wvalid && wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wLane_ff <= wstrb[0];
      end
      else if (doWrite)
        wHeld_ff <= 1'b0;
    end
  end

  // control bits live in byte lane 0 only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_ff   <= CTRL_RESET;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awAddr_ff == ADDR_CTRL || awAddr_ff == ADDR_STATUS || awAddr_ff == ADDR_FTS) ?
                   RESP_OKAY : RESP_SLVERR;
      if (awAddr_ff == ADDR_CTRL && wLane_ff)
        ctrl_ff <= wData_ff[2:0];
    end
    else if (bvalid_ff && bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      unique case (araddr)
        ADDR_CTRL:   rdata_ff <= {29'h0, ctrl_ff};
        ADDR_STATUS: rdata_ff <= statusWord;
        ADDR_FTS:    rdata_ff <= {24'h0, FTS_COUNT};
        default:
        begin
          rdata_ff <= 32'h0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && rready)
      rvalid_ff <= 1'b0;
  end
endmodule

// ---- verif/pmh_user_model.sv ----
// Purpose: user logic model on the requester stream and power handshake
// Assumes: one packet at a time; acknowledge is never withdrawn
// Notes:   idle last line toggles so a stale value is never trusted
`timescale 1ns/1ns
module pmh_user_model
  import pmh_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       pktReq,
  input  wire logic [3:0] pktLen,
  input  wire logic [7:0] ackDelay,
  // core side
  input  wire logic       accept,
  input  wire logic [1:0] fn0State,
  input  wire logic       notice,
  output logic            reqValid,
  output logic            reqLast,
  output logic            powerChangeAck,
  output logic [7:0]      beats
);
  logic [3:0] left_ff;
  logic [7:0] wait_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reqValid <= 1'b0;
      reqLast  <= 1'b0;
      left_ff  <= 4'h0;
      beats    <= 8'h00;
    end
    else if (reqValid && accept)
    begin
      beats    <= beats + 8'h01;
      left_ff  <= left_ff - 4'h1;
      reqValid <= (left_ff != 4'h1);
      reqLast  <= (left_ff == 4'h2);
    end
    else if (!reqValid && pktReq && fn0State == DST_D0 && !notice)
    begin
      reqValid <= 1'b1;
      left_ff  <= pktLen;
      reqLast  <= (pktLen == 4'h1);
    end
    else if (!reqValid)
      reqLast <= ~reqLast;
  end

  // a packet in flight is finished before the acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      powerChangeAck <= 1'b0;
      wait_ff        <= 8'h00;
    end
    else if (notice && !reqValid && !powerChangeAck)
    begin
      if (wait_ff == ackDelay)
        powerChangeAck <= 1'b1;
      else
        wait_ff <= wait_ff + 8'h01;
    end
  end
endmodule

// ---- verif/pmh_core_tb.sv ----
// Purpose: self-checking bench for the power management handshake core
// Assumes: register reads are checked by a monitor from a queue
// Notes:   pulse outputs are counted so late checks still see them
`timescale 1ns/1ns
module pmh_core_tb
  import pmh_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n, linkTrained, linkIdle, l1AckRx, turnoffMsgRx, asyncClkMode;
  logic dstateWrValid, dstateWrFunc, enterL1DllpTx, pmeToAckTx, layersDisabled;
  logic requesterValid, requesterLast, requester_accept_out, completerAccept;
  logic turnoff_notice_out, powerChangeAck, pktReq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  dstateWrValue, bresp, rresp;
  logic [2:0]  linkState;
  logic [3:0]  functionPowerState, awaddr, wstrb, araddr, pktLen;
  logic [7:0]  ftsAdvertised, ackDelay, beats, b0, p0;
  logic [7:0]  l1Cnt_ff = 8'h00;
  logic [7:0]  ackCnt_ff = 8'h00;
  logic [31:0] wdata, rdata;
  logic [33:0] expRd;
  logic [33:0] expQ[$];
  int          miscompares = 0;
  int          compares = 0;
  int          seed = 32;
  pmh_dstate_t vals[3] = '{DST_D1, DST_D2, DST_D3HOT};

  always #20 clk = ~clk;

  pmh_core i_pmh_core (.clk, .rst_n, .linkTrained, .linkIdle, .l1AckRx, .turnoffMsgRx,
    .asyncClkMode, .dstateWrValid, .dstateWrFunc, .dstateWrValue, .ftsAdvertised, .linkState,
    .enterL1DllpTx, .pmeToAckTx, .layersDisabled, .requesterValid, .requesterLast,
    .requester_accept_out, .completerAccept, .functionPowerState, .turnoff_notice_out,
    .powerChangeAck, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  pmh_user_model i_pmh_user_model (.clk, .rst_n, .pktReq, .pktLen, .ackDelay,
    .accept(requester_accept_out), .fn0State(functionPowerState[1:0]),
    .notice(turnoff_notice_out), .reqValid(requesterValid), .reqLast(requesterLast),
    .powerChangeAck, .beats);

  always @(posedge clk)
  begin
    l1Cnt_ff <= l1Cnt_ff + 8'(enterL1DllpTx);
    ackCnt_ff <= ackCnt_ff + 8'(pmeToAckTx);
    if (rvalid && rready && expQ.size() > 0)
    begin
      expRd = expQ.pop_front();
      compares++;
      if ({rresp, rdata} !== expRd)
      begin
        miscompares++;
        $display("[FAIL] %0t read got %h expected %h", $time, {rresp, rdata}, expRd);
      end
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aDone, wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aDone && wDone))
    begin
      @(posedge clk);
      aDone |= awvalid & awready;
      wDone |= wvalid & wready;
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end
    do @(posedge clk); while (!bvalid);
    chk(8'(bresp), 8'(er));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    expQ.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic dwr(input logic f, input logic [1:0] v);
    dstateWrFunc <= f;
    dstateWrValue <= v;
    dstateWrValid <= 1'b1;
    @(posedge clk);
    dstateWrValid <= 1'b0;
    cyc(2);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // generous: the idle spans dominate the run
  initial
  begin
    cyc(6000);
    miscompares++;
    end_sim;
  end

  initial
  begin
    {rst_n, linkTrained, linkIdle, l1AckRx, turnoffMsgRx, asyncClkMode, pktReq, pktLen} = '0;
    {dstateWrValid, dstateWrFunc, dstateWrValue, awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, ackDelay} = '0;
    wstrb = 4'hF;
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    chk(ftsAdvertised, 8'hFF);
    chk(8'(linkState), 8'(LNK_DOWN));
    chk(8'({layersDisabled, turnoff_notice_out, requester_accept_out, completerAccept}), 8'h03);
    axi_rd(ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    // control bits sit in lane 0: a write without it must not land
    wstrb <= 4'hE;
    axi_wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    axi_wr(ADDR_FTS, 32'($random(seed)), RESP_OKAY);
    axi_rd(ADDR_FTS, 32'h0000_00FF, RESP_OKAY);
    axi_rd(4'hC, 32'h0000_0000, RESP_SLVERR);
    axi_wr(4'hC, 32'($random(seed)), RESP_SLVERR);
    linkTrained <= 1'b1;
    cyc(3);
    chk(8'(linkState), 8'(LNK_L0));
    linkIdle <= 1'b1;
    cyc(170);
    chk(8'(linkState), 8'(LNK_L0));
    cyc(20);
    chk(8'(linkState), 8'(LNK_L0S));
    linkIdle <= 1'b0;
    cyc(2);
    chk(8'(linkState), 8'(LNK_L0));
    asyncClkMode <= 1'b1;
    linkIdle <= 1'b1;
    cyc(190);
    chk(8'(linkState), 8'(LNK_L0));
    linkIdle <= 1'b0;
    asyncClkMode <= 1'b0;
    dwr(1'b1, DST_D3HOT);
    chk(8'(functionPowerState), 8'h0C);
    chk(8'(completerAccept), 8'h00);
    chk(8'(requester_accept_out), 8'h01);
    // status: fn1 D3hot, aspm active, link in L1 entry
    axi_rd(ADDR_STATUS, 32'h0000_0C23, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    chk(8'(completerAccept), 8'h01);
    axi_wr(ADDR_CTRL, 32'h0000_0005, RESP_OKAY);
    chk(8'(completerAccept), 8'h01);
    axi_wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    chk(8'(completerAccept), 8'h00);
    dwr(1'b1, DST_D0);
    cyc(3);
    chk(8'(linkState), 8'(LNK_L0));
    foreach (vals[i])
    begin
      b0 = beats;
      p0 = l1Cnt_ff;
      pktLen <= 4'h4;
      pktReq <= 1'b1;
      while (beats == b0) @(posedge clk);
      pktReq <= 1'b0;
      dwr(1'b0, vals[i]);
      cyc(20);
      chk(beats - b0, 8'h04);
      chk(8'(functionPowerState), 8'(vals[i]));
      chk(8'(linkState), 8'(LNK_L1ENT));
      chk(l1Cnt_ff - p0, 8'h01);
      chk(8'(requester_accept_out), 8'h00);
      l1AckRx <= 1'b1;
      cyc(1);
      l1AckRx <= 1'b0;
      cyc(2);
      chk(8'(linkState), 8'(LNK_L1));
      chk(8'(requester_accept_out), 8'h00);
      dwr(1'b0, DST_D0);
      chk(8'(linkState), 8'(LNK_L0));
      chk(8'(requester_accept_out), 8'h01);
    end
    ackDelay <= 8'(($random(seed) & 32'hF) + 2);
    p0 = ackCnt_ff;
    turnoffMsgRx <= 1'b1;
    cyc(1);
    turnoffMsgRx <= 1'b0;
    cyc(1);
    chk(8'(linkState), 8'(LNK_L23));
    while (!powerChangeAck)
    begin
      chk(8'(turnoff_notice_out), 8'h01);
      cyc(1);
    end
    cyc(1);
    chk(8'(turnoff_notice_out), 8'h00);
    chk(8'(pmeToAckTx), 8'h01);
    cyc(1);
    chk(ackCnt_ff - p0, 8'h01);
    chk(8'({layersDisabled, requester_accept_out, completerAccept}), 8'h04);
    turnoffMsgRx <= 1'b1;
    cyc(1);
    turnoffMsgRx <= 1'b0;
    dwr(1'b0, DST_D1);
    chk(8'(turnoff_notice_out), 8'h00);
    chk(8'(functionPowerState), 8'h00);
    chk(ackCnt_ff - p0, 8'h01);
    // only a reset reopens the interfaces after turn-off
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    chk(8'({layersDisabled, turnoff_notice_out, requester_accept_out, completerAccept}), 8'h03);
    chk(8'(functionPowerState), 8'h00);
    end_sim;
  end
endmodule
